// [src/fiotoc_map.svh]
`ifndef FIOTOC_MAP_SVH
`define FIOTOC_MAP_SVH
`define FT_TYP_POLL   8'h36
`define FT_TYP_SETO   8'h37
`define FT_TYP_TRK    8'h38
`define FT_TYP_CPX    8'h39
`define FT_RSP_POLL   8'hB6
`define FT_RSP_SETO   8'hB7
`define FT_RSP_TRK    8'hB8
`define FT_RSP_CPX    8'hB9
`define FT_N_IN       7'h78
`define FT_N_OUT      7'h68
`define FT_OUT_BYTES  13
`define FT_SETO_LEN   6'h1B
`define FT_PBUF_MAX   6'h3C
`define FT_TRK_ITEMS  8'h10
`define FT_CPX_ITEMS  8'h08
`define FT_BLK_MAX    11'h0FF
`define FT_QDEPTH     11'h400
`define FT_ST_SEQ     0
`define FT_ST_REP     1
`define FT_ST_BUF     2
`define FT_ST_ENT     3
`define FT_CF_PULSE   7
`define FT_CF_GATE    5
`define FT_CF_EN      4
`define FT_CF_HIGH    3
`define FT_CF_TRIG    1
`define FT_CLK_NS     5
`define FT_TICK_NS    1000000
`endif

// [src/fiotoc_pkg.sv]
`default_nettype none
package fiotoc_pkg;
  typedef enum logic [1:0] {
    ST_RX   = 2'b00,
    ST_EXEC = 2'b01,
    ST_RESP = 2'b10
  } fiotoc_phase_type;
  typedef struct packed {
    logic       vld;
    logic [7:0] dat;
    logic       last;
  } fiotoc_byte_type;
  typedef struct packed {
    logic       en;
    logic [6:0] outn;
    logic [6:0] inn;
    logic       inv;
  } fiotoc_trk_type;
  typedef struct packed {
    logic        en;
    logic [6:0]  outn;
    logic [6:0]  inn;
    logic [7:0]  flg;
    logic [15:0] prim;
    logic [15:0] sec;
    logic [15:0] cnt;
    logic        ph;
    logic        run;
  } fiotoc_cpx_type;
  typedef struct packed {
    fiotoc_phase_type       ph;
    logic [119:0]           sync1;
    logic [119:0]           sync2;
    logic [119:0]           rep;
    logic                   lsl1;
    logic                   lsl2;
    logic                   lsl_sys;
    logic [6:0]             scan;
    logic [9:0]             wptr;
    logic [9:0]             head;
    logic [10:0]            qcnt;
    logic [7:0]             sent;
    logic [7:0]             blk;
    logic                   blk_seen;
    logic                   qovf;
    logic [59:0][7:0]       pbuf;
    logic [5:0]             idx;
    logic                   ferr;
    logic [7:0]             typ;
    logic [4:0]             item;
    logic                   viol;
    fiotoc_trk_type [7:0]   trk;
    fiotoc_trk_type [7:0]   wtrk;
    fiotoc_cpx_type [7:0]   cpx;
    fiotoc_cpx_type [7:0]   wcpx;
    logic [103:0]           set_data;
    logic [103:0]           set_ctrl;
    logic [103:0]           out;
    logic [103:0]           wout;
    logic [2:0]             rk;
    logic [17:0]            tick_cnt;
    logic [7:0]             rsp_st;
    logic [31:0]            rsp_ts;
    logic [9:0]             rsp_ptr;
    logic [1:0]             sub;
    logic [9:0]             nx;
    logic [9:0]             oi;
    logic                   rdy;
    fiotoc_byte_type        resp;
  } fiotoc_state_type;
endpackage
`default_nettype wire

// [src/fiotoc_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fiotoc_map.svh"
module fiotoc_top #(
  parameter int unsigned TICK_CYC = `FT_TICK_NS / `FT_CLK_NS
) (
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        ce,
  input  wire fiotoc_pkg::fiotoc_byte_type cmd,
  output var  logic                        cmd_ready,
  output var  fiotoc_pkg::fiotoc_byte_type resp,
  input  wire logic                        resp_ready,
  input  wire logic [119:0]                field_in,
  input  wire logic [119:0]                ignore_mask,
  input  wire logic [31:0]                 timestamp,
  input  wire logic                        mains_phase_lost_pin,
  output var  logic [103:0]                field_out,
  output var  logic [103:0]                field_out_ctrl,
  output var  logic                        sys_line_sync_lost
);
  import fiotoc_pkg::*;

  fiotoc_state_type r_reg, r_next;
  logic [23:0]      mem [0:1023];
  logic             wr;
  logic [23:0]      wd;
  logic [23:0]      rd;
  logic [10:0]      pend;
  logic             same;

  assign rd = mem[r_reg.rsp_ptr];

  always_comb begin
    fiotoc_state_type n;
    logic enq, th, ch, tf, cf, done;
    logic [2:0] ts, cs, tfs, cfs;
    logic [5:0] b;
    logic [6:0] o, i;
    logic [7:0] nit, lim;
    logic [9:0] tb, ln;
    logic [7:0] byt;
    logic [103:0] own;
    n = r_reg;
    enq = 1'b0; th = 1'b0; ch = 1'b0; tf = 1'b0; cf = 1'b0; done = 1'b0;
    ts = '0; cs = '0; tfs = '0; cfs = '0; b = '0; o = '0; i = '0;
    nit = r_reg.pbuf[0]; lim = '0; tb = '0; ln = '0; byt = '0; own = '0;
    wr = 1'b0; wd = '0;
    pend = r_reg.qcnt - 11'(r_reg.sent);
    same = r_reg.blk_seen && r_reg.pbuf[0] == r_reg.blk;
    n.sync1 = field_in;
    n.sync2 = r_reg.sync1;
    n.lsl1 = mains_phase_lost_pin;
    n.lsl2 = r_reg.lsl1;
    n.lsl_sys = r_reg.lsl2;
    n.scan = (r_reg.scan == `FT_N_IN - 7'h01) ? '0 : r_reg.scan + 7'h01;
    if (r_reg.sync2[r_reg.scan] != r_reg.rep[r_reg.scan]) begin
      n.rep[r_reg.scan] = r_reg.sync2[r_reg.scan];
      enq = !ignore_mask[r_reg.scan];
      wd = {r_reg.sync2[r_reg.scan], r_reg.scan, timestamp[15:0]};
    end
    for (int j = 0; j < 8; j++) begin
      if (r_reg.trk[j].en) own[r_reg.trk[j].outn] = 1'b1;
      if (r_reg.cpx[j].en) own[r_reg.cpx[j].outn] = 1'b1;
    end
    unique case (r_reg.ph)
      ST_RX: begin
        if (cmd.vld && r_reg.rdy) begin
          if (r_reg.idx == '0) n.typ = cmd.dat;
          else if (r_reg.idx <= `FT_PBUF_MAX)
            n.pbuf[6'(r_reg.idx - 6'h01)] = cmd.dat;
          else n.ferr = 1'b1;
          if (r_reg.idx != 6'h3F) n.idx = r_reg.idx + 6'h01;
          if (cmd.last) begin
            n.ph = ST_EXEC;
            n.item = '0;
            n.viol = 1'b0;
            n.wtrk = r_reg.trk;
            n.wcpx = r_reg.cpx;
          end
        end
      end
      ST_EXEC: begin
        n.ph = ST_RESP;
        n.nx = '0;
        n.sub = '0;
        n.resp.vld = 1'b0;
        n.rsp_ts = timestamp;
        case (r_reg.typ)
          `FT_TYP_POLL: begin
            if (same) begin
              n.rsp_st[`FT_ST_REP] = 1'b1;
              n.rsp_st[`FT_ST_SEQ] = 1'b0;
            end else begin
              n.head = r_reg.head + 10'(r_reg.sent);
              n.qcnt = pend;
              n.sent = (pend > `FT_BLK_MAX) ? 8'hFF : pend[7:0];
              n.rsp_st = '0;
              n.rsp_st[`FT_ST_ENT] = pend > `FT_BLK_MAX;
              n.rsp_st[`FT_ST_BUF] = r_reg.qovf;
              n.rsp_st[`FT_ST_SEQ] = r_reg.blk_seen &&
                r_reg.pbuf[0] != r_reg.blk + 8'h01;
              n.qovf = 1'b0;
            end
            n.rsp_ptr = n.head;
            n.blk = r_reg.pbuf[0];
            n.blk_seen = 1'b1;
          end
          `FT_TYP_SETO: begin
            n.rsp_st = {6'h00, r_reg.lsl2, 1'b1};
            if (r_reg.idx == `FT_SETO_LEN && !r_reg.ferr) begin
              for (int j = 0; j < `FT_OUT_BYTES; j++) begin
                n.set_data[8*j +: 8] = r_reg.pbuf[j];
                n.set_ctrl[8*j +: 8] = r_reg.pbuf[j + `FT_OUT_BYTES];
              end
              n.out = (r_reg.out & own) | (n.set_data & ~own);
              n.rsp_st[0] = 1'b0;
            end
          end
          `FT_TYP_TRK, `FT_TYP_CPX: begin
            lim = (r_reg.typ == `FT_TYP_TRK) ? `FT_TRK_ITEMS : `FT_CPX_ITEMS;
            done = 8'(r_reg.item) >= nit || nit > lim || r_reg.ferr;
            if (!done) begin
              n.ph = ST_EXEC;
              n.item = r_reg.item + 5'h01;
              if (r_reg.typ == `FT_TYP_TRK) b = 6'(2 * r_reg.item + 1);
              else b = 6'(7 * r_reg.item + 1);
              o = r_reg.pbuf[b][6:0];
              i = (r_reg.typ == `FT_TYP_TRK) ? r_reg.pbuf[b + 6'h01][6:0]
                                             : r_reg.pbuf[b + 6'h05][6:0];
              for (int j = 0; j < 8; j++) begin
                if (r_reg.wtrk[j].en && r_reg.wtrk[j].outn == o) begin
                  th = 1'b1; ts = 3'(j);
                end
                if (r_reg.wcpx[j].en && r_reg.wcpx[j].outn == o) begin
                  ch = 1'b1; cs = 3'(j);
                end
                if (!r_reg.wtrk[j].en) begin tf = 1'b1; tfs = 3'(j); end
                if (!r_reg.wcpx[j].en) begin cf = 1'b1; cfs = 3'(j); end
              end
              if (o < `FT_N_OUT && i < `FT_N_IN) begin
                if (r_reg.typ == `FT_TYP_TRK) begin
                  if (r_reg.pbuf[b][7]) begin
                    if (!th && !tf) n.viol = 1'b1;
                    else begin
                      n.wtrk[th ? ts : tfs] = {1'b1, o, i,
                        r_reg.pbuf[b + 6'h01][7]};
                      if (ch) n.wcpx[cs].en = 1'b0;
                    end
                  end else if (th) begin
                    n.wtrk[ts].en = 1'b0;
                    n.wout[o] = r_reg.set_data[o];
                  end
                end else if (r_reg.pbuf[b + 6'h06][`FT_CF_EN]) begin
                  if (!ch && !cf) n.viol = 1'b1;
                  else begin
                    n.wcpx[ch ? cs : cfs] = {1'b1, o, i,
                      r_reg.pbuf[b + 6'h06],
                      r_reg.pbuf[b + 6'h01], r_reg.pbuf[b + 6'h02],
                      r_reg.pbuf[b + 6'h03], r_reg.pbuf[b + 6'h04],
                      r_reg.pbuf[b + 6'h01], r_reg.pbuf[b + 6'h02],
                      2'b00};
                    if (th) n.wtrk[ts].en = 1'b0;
                  end
                end else if (ch) begin
                  n.wcpx[cs].en = 1'b0;
                  n.wout[o] = r_reg.set_data[o];
                end
              end
            end else begin
              n.rsp_st = {7'h00, r_reg.viol || nit > lim || r_reg.ferr};
              if (n.rsp_st[0] == 1'b0) begin
                n.trk = r_reg.wtrk;
                n.cpx = r_reg.wcpx;
                n.out = r_reg.wout;
                if (r_reg.typ == `FT_TYP_TRK && nit == 8'h00) begin
                  for (int j = 0; j < 8; j++) begin
                    if (r_reg.trk[j].en)
                      n.out[r_reg.trk[j].outn] =
                        r_reg.set_data[r_reg.trk[j].outn];
                    n.trk[j].en = 1'b0;
                  end
                end
              end
            end
          end
          default: begin
            // unknown type: drop the frame silently and rearm
            n.ph = ST_RX;
            n.idx = '0;
            n.ferr = 1'b0;
          end
        endcase
      end
      ST_RESP: begin
        tb = (r_reg.typ == `FT_TYP_POLL) ?
             10'd3 + 10'(r_reg.sent) * 10'd3 : 10'd1;
        ln = tb + ((r_reg.typ == `FT_TYP_SETO) ? 10'd1 : 10'd5);
        if (!r_reg.resp.vld || resp_ready) begin
          if (r_reg.nx < ln) begin
            if (r_reg.nx == '0) begin
              case (r_reg.typ)
                `FT_TYP_POLL: byt = `FT_RSP_POLL;
                `FT_TYP_SETO: byt = `FT_RSP_SETO;
                `FT_TYP_TRK:  byt = `FT_RSP_TRK;
                default:      byt = `FT_RSP_CPX;
              endcase
            end else if (r_reg.nx < tb) begin
              if (r_reg.nx == 10'd1) byt = r_reg.blk;
              else if (r_reg.nx == 10'd2) byt = r_reg.sent;
              else begin
                byt = (r_reg.sub == 2'd0) ? rd[23:16] :
                      (r_reg.sub == 2'd1) ? rd[15:8] : rd[7:0];
                n.sub = (r_reg.sub == 2'd2) ? 2'd0 : r_reg.sub + 2'd1;
                if (r_reg.sub == 2'd2) n.rsp_ptr = r_reg.rsp_ptr + 10'd1;
              end
            end else if (r_reg.nx == tb) byt = r_reg.rsp_st;
            else byt = r_reg.rsp_ts[8*(3 - int'(r_reg.nx - tb - 10'd1)) +: 8];
            n.resp = {1'b1, byt, r_reg.nx == ln - 10'd1};
            n.oi = r_reg.nx;
            n.nx = r_reg.nx + 10'd1;
          end else begin
            n.resp.vld = 1'b0;
            n.ph = ST_RX;
            n.idx = '0;
            n.ferr = 1'b0;
          end
        end
      end
      default: n.ph = ST_RX;
    endcase
    if (r_reg.ph != ST_EXEC) begin
      n.rk = r_reg.rk + 3'd1;
      if (r_reg.trk[r_reg.rk].en)
        n.out[r_reg.trk[r_reg.rk].outn] =
          r_reg.sync2[r_reg.trk[r_reg.rk].inn] ^ r_reg.trk[r_reg.rk].inv;
      n.tick_cnt = (r_reg.tick_cnt == 18'(TICK_CYC - 1)) ? '0
                   : r_reg.tick_cnt + 18'd1;
      for (int j = 0; j < 8; j++) begin
        if (r_reg.tick_cnt == '0 && r_reg.cpx[j].en) begin
          if (r_reg.cpx[j].flg[`FT_CF_GATE] &&
              !r_reg.sync2[r_reg.cpx[j].inn]) begin
            n.cpx[j].run = 1'b0;
            n.cpx[j].ph = 1'b0;
            n.cpx[j].cnt = r_reg.cpx[j].prim;
          end else if (!r_reg.cpx[j].run) begin
            n.cpx[j].run = r_reg.cpx[j].flg[`FT_CF_GATE] ||
              !r_reg.cpx[j].flg[`FT_CF_TRIG] ||
              r_reg.sync2[r_reg.cpx[j].inn];
          end else begin
            n.out[r_reg.cpx[j].outn] =
              r_reg.cpx[j].flg[`FT_CF_HIGH] ^ r_reg.cpx[j].ph;
            if (r_reg.cpx[j].cnt != '0)
              n.cpx[j].cnt = r_reg.cpx[j].cnt - 16'd1;
            else if (!r_reg.cpx[j].ph) begin
              n.cpx[j].ph = 1'b1;
              n.cpx[j].cnt = r_reg.cpx[j].sec;
            end else if (r_reg.cpx[j].sec == '0) begin
              n.cpx[j].cnt = '0;
            end else if (r_reg.cpx[j].flg[`FT_CF_PULSE]) begin
              n.cpx[j].en = 1'b0;
              n.out[r_reg.cpx[j].outn] =
                r_reg.set_data[r_reg.cpx[j].outn];
            end else begin
              n.cpx[j].ph = 1'b0;
              n.cpx[j].cnt = r_reg.cpx[j].prim;
            end
          end
        end
      end
    end
    // snapshot after this cycle's refresh so no output update is lost
    if (r_reg.ph == ST_RX && n.ph == ST_EXEC) n.wout = n.out;
    if (enq) begin
      if (n.qcnt == `FT_QDEPTH) n.qovf = 1'b1;
      else begin
        wr = 1'b1;
        n.wptr = r_reg.wptr + 10'd1;
        n.qcnt = n.qcnt + 11'd1;
      end
    end
    n.rdy = n.ph == ST_RX;
    r_next = n;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) r_reg <= '0;
    else if (ce) r_reg <= r_next;
  end

  always_ff @(posedge core_clk) begin
    if (ce && wr) mem[r_reg.wptr] <= wd;
  end

  assign cmd_ready = r_reg.rdy;
  assign resp = r_reg.resp;
  assign field_out = r_reg.out;
  assign field_out_ctrl = r_reg.set_ctrl;
  assign sys_line_sync_lost = r_reg.lsl_sys;

  default clocking dc @(posedge core_clk); endclocking
  default disable iff (sys_rst || !ce);
  wire exec_poll = r_reg.ph == ST_EXEC && r_reg.typ == `FT_TYP_POLL;
  chk_poll_type: assert property (
    r_reg.ph == ST_RESP && r_reg.resp.vld && r_reg.oi == '0 &&
    r_reg.typ == `FT_TYP_POLL |-> r_reg.resp.dat == 8'hB6)
    else $error("poll answer type wrong");
  chk_blk_echo: assert property (
    r_reg.ph == ST_RESP && r_reg.resp.vld && r_reg.oi == 10'd1 &&
    r_reg.typ == `FT_TYP_POLL |-> r_reg.resp.dat == r_reg.pbuf[0])
    else $error("block number not echoed");
  chk_ent_over: assert property (exec_poll && !same && pend > 11'd255
    |=> r_reg.rsp_st[3] && r_reg.sent == 8'hFF && r_reg.rsp_st[7:4] == 4'h0)
    else $error("entry overflow not flagged");
  chk_repeat_same: assert property (exec_poll && same
    |=> r_reg.rsp_st[1] && $stable(r_reg.sent) && $stable(r_reg.head))
    else $error("repeat not resent");
  chk_seq_err: assert property (exec_poll && r_reg.blk_seen &&
    r_reg.pbuf[0] != r_reg.blk + 8'h01 && !same |=> r_reg.rsp_st[0])
    else $error("sequence error missed");
  chk_trk_reject: assert property (r_reg.ph == ST_EXEC &&
    r_reg.typ == `FT_TYP_TRK && r_reg.viol ##1 r_reg.ph == ST_RESP
    |-> r_reg.trk == $past(r_reg.trk, 1) && r_reg.rsp_st == 8'h01)
    else $error("tracking over limit applied");
  chk_sync_sys: assert property (r_reg.lsl2 ##1 r_reg.lsl2
    |-> sys_line_sync_lost)
    else $error("reference loss not reported");
  chk_ts_bytes: assert property (r_reg.resp.vld &&
    r_reg.typ == `FT_TYP_TRK && r_reg.oi == 10'd2
    |-> r_reg.resp.dat == r_reg.rsp_ts[31:24])
    else $error("timestamp byte wrong");
  cov_repeat: cover property (exec_poll && same);
  cov_trk_viol: cover property (r_reg.ph == ST_EXEC && r_reg.viol);
  cov_seto: cover property (r_reg.resp.vld && r_reg.typ == `FT_TYP_SETO);
  cov_pulse_end: cover property (r_reg.cpx[7].en ##1 !r_reg.cpx[7].en);
endmodule
`default_nettype wire

// [bench/fiotoc_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fiotoc_ctrl_model (
  input  wire logic                        core_clk,
  input  wire logic                        cmd_ready,
  output var  fiotoc_pkg::fiotoc_byte_type cmd,
  input  wire fiotoc_pkg::fiotoc_byte_type resp,
  output var  logic                        resp_ready
);
  import fiotoc_pkg::*;
  logic [7:0] rb [0:79];
  int         rn;
  logic       slow;
  initial begin
    cmd = '0;
    resp_ready = 1'b0;
    slow = 1'b0;
  end
  // one frame, one byte per accepting edge, held until taken
  task send_frame(input logic [7:0] f [0:79], input int n);
    int i;
    int w;
    for (i = 0; i < n; i++) begin
      w = 0;
      @(negedge core_clk);
      while (!cmd_ready && w < 4000) begin
        @(negedge core_clk);
        w++;
      end
      cmd.vld = 1'b1;
      cmd.dat = f[i];
      cmd.last = (i == n - 1);
      @(posedge core_clk);
    end
    @(negedge core_clk);
    cmd.vld = 1'b0;
    cmd.last = 1'b0;
    // released bus shows no stale byte
    cmd.dat = ~cmd.dat;
  endtask
  // collect the answer; slow mode stalls every other cycle
  task get_resp();
    int w;
    rn = 0;
    w = 0;
    while (w < 4000) begin
      @(negedge core_clk);
      resp_ready = !(slow && (w % 2 == 1));
      w++;
      if (resp.vld && resp_ready) begin
        if (rn < 80) rb[rn] = resp.dat;
        rn++;
        if (resp.last) begin
          @(negedge core_clk);
          resp_ready = 1'b0;
          w = 4000;
        end
      end
    end
  endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fiotoc_pkg::*;
  logic            core_clk;
  logic            sys_rst;
  logic            ce;
  fiotoc_byte_type cmd;
  logic            cmd_ready;
  fiotoc_byte_type resp;
  logic            resp_ready;
  logic [119:0]    field_in;
  logic [119:0]    ignore_mask;
  logic [31:0]     timestamp;
  logic            lost;
  logic [103:0]    field_out;
  logic [103:0]    field_out_ctrl;
  logic            sys_lost;
  logic [7:0]      fr [0:79];
  logic [7:0]      ex [0:79];
  logic [7:0]      ent [0:5];
  int              fn;
  int              en;
  int              err_total;
  int              checks_done;
  int              i;
  logic            saw;
  localparam logic [103:0] SD = 104'h00_1234_5678_9ABC_DEF0_1122_33FC;
  localparam logic [103:0] SC = 104'h0F_0E0D_0C0B_0A09_0807_0605_0403;
  fiotoc_top #(.TICK_CYC(4)) dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .cmd(cmd),
    .cmd_ready(cmd_ready), .resp(resp), .resp_ready(resp_ready),
    .field_in(field_in), .ignore_mask(ignore_mask), .timestamp(timestamp),
    .mains_phase_lost_pin(lost), .field_out(field_out),
    .field_out_ctrl(field_out_ctrl), .sys_line_sync_lost(sys_lost)
  );
  fiotoc_ctrl_model model_u (
    .core_clk(core_clk), .cmd_ready(cmd_ready), .cmd(cmd),
    .resp(resp), .resp_ready(resp_ready)
  );
  always #2.5 core_clk = ~core_clk;
  task conclude();
    $display("counts: %0d checks, %0d mismatches", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task cmp(input logic [103:0] got, input logic [103:0] exp, input string s);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task xfer(input string s);
    int k;
    model_u.send_frame(fr, fn);
    model_u.get_resp();
    cmp(model_u.rn, en, {s, " length"});
    for (k = 0; k < en && k < 80; k++) cmp(model_u.rb[k], ex[k], s);
  endtask
  task ts_tail(input int k);
    ex[k] = timestamp[31:24];
    ex[k+1] = timestamp[23:16];
    ex[k+2] = timestamp[15:8];
    ex[k+3] = timestamp[7:0];
    en = k + 4;
  endtask
  task poll(input logic [7:0] b, input logic [7:0] st, input int ne);
    int k;
    fr[0] = 8'h36;
    fr[1] = b;
    fn = 2;
    ex[0] = 8'hB6;
    ex[1] = b;
    ex[2] = 8'(ne);
    for (k = 0; k < 3 * ne; k++) ex[3+k] = ent[k];
    ex[3+3*ne] = st;
    ts_tail(4 + 3 * ne);
    xfer("poll");
  endtask
  task setout(input int n, input logic [7:0] st);
    int k;
    fr[0] = 8'h37;
    for (k = 0; k < 13; k++) fr[1+k] = SD[8*k+:8];
    for (k = 0; k < 13; k++) fr[14+k] = SC[8*k+:8];
    fn = n;
    ex[0] = 8'hB7;
    ex[1] = st;
    en = 2;
    xfer("set outputs");
  endtask
  // items: output base, input base, count, expected status
  task track(input int ob, input int ib, input int n, input logic [7:0] st);
    int k;
    fr[0] = 8'h38;
    fr[1] = 8'(n);
    for (k = 0; k < n; k++) fr[2+2*k] = 8'h80 | 8'(ob + k);
    for (k = 0; k < n; k++) fr[3+2*k] = 8'(ib + k);
    fn = 2 + 2 * n;
    ex[0] = 8'hB8;
    ex[1] = st;
    ts_tail(2);
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    ce = 1'b1;
    field_in = '0;
    ignore_mask = '0;
    ignore_mask[5] = 1'b1;
    timestamp = 32'hA1B2C3D4;
    lost = 1'b0;
    err_total = 0;
    checks_done = 0;
    repeat (4) @(negedge core_clk);
    cmp(cmd_ready, 1'b0, "ready in reset");
    cmp(field_out, '0, "outputs in reset");
    sys_rst = 1'b0;
    repeat (2) @(negedge core_clk);
    poll(8'h01, 8'h00, 0);
    $display("test empty poll done");
    field_in[3] = 1'b1;
    field_in[5] = 1'b1;
    repeat (200) @(negedge core_clk);
    ent[0] = 8'h83;
    ent[1] = 8'hC3;
    ent[2] = 8'hD4;
    poll(8'h02, 8'h00, 1);
    model_u.slow = 1'b1;
    poll(8'h02, 8'h02, 1);
    model_u.slow = 1'b0;
    poll(8'h05, 8'h01, 0);
    poll(8'h06, 8'h00, 0);
    poll(8'hFF, 8'h01, 0);
    poll(8'h00, 8'h00, 0);
    $display("test block sequence done");
    setout(27, 8'h00);
    repeat (4) @(negedge core_clk);
    cmp(field_out, SD, "output data");
    cmp(field_out_ctrl, SC, "output control");
    setout(10, 8'h01);
    cmp(field_out, SD, "short frame ignored");
    lost = 1'b1;
    repeat (8) @(negedge core_clk);
    cmp(sys_lost, 1'b1, "system loss flag");
    setout(27, 8'h02);
    lost = 1'b0;
    $display("test set outputs done");
    track(0, 3, 2, 8'h00);
    fr[5] = 8'h84;
    xfer("track");
    repeat (40) @(negedge core_clk);
    cmp(field_out[1:0], 2'b11, "track follow");
    ce = 1'b0;
    field_in[3] = 1'b0;
    field_in[4] = 1'b1;
    repeat (40) @(negedge core_clk);
    cmp(field_out[1:0], 2'b11, "frozen while disabled");
    ce = 1'b1;
    repeat (40) @(negedge core_clk);
    cmp(field_out[1:0], 2'b00, "track invert");
    track(2, 10, 7, 8'h01);
    xfer("track over limit");
    repeat (40) @(negedge core_clk);
    cmp(field_out[8:2], SD[8:2], "rejected untouched");
    track(2, 10, 7, 8'h00);
    fr[14] = 8'hF0;
    xfer("track invalid item");
    repeat (40) @(negedge core_clk);
    cmp(field_out[7:2], 6'h00, "valid items applied");
    track(20, 30, 17, 8'h01);
    xfer("track count 17");
    field_in[3] = 1'b1;
    track(0, 0, 0, 8'h00);
    xfer("track count 0");
    repeat (40) @(negedge core_clk);
    cmp(field_out, SD, "tracking released");
    $display("test tracking done");
    fr[0] = 8'h39;
    fr[1] = 8'h09;
    for (i = 0; i < 63; i++) fr[2+i] = (i % 7 == 0) ? 8'(20 + i / 7) : 8'h01;
    fn = 65;
    ex[0] = 8'hB9;
    ex[1] = 8'h01;
    ts_tail(2);
    xfer("complex over limit");
    fr[1] = 8'h01;
    fr[2] = 8'h08;
    fr[3] = 8'h00;
    fr[4] = 8'h02;
    fr[5] = 8'h00;
    fr[6] = 8'h03;
    fr[7] = 8'h00;
    fr[8] = 8'h98;
    fn = 9;
    ex[1] = 8'h00;
    xfer("complex pulse");
    saw = 1'b0;
    for (i = 0; i < 150; i++) begin
      @(negedge core_clk);
      if (field_out[8] === 1'b0) saw = 1'b1;
    end
    cmp(saw, 1'b1, "pulse seen");
    cmp(field_out[8], SD[8], "pulse returns");
    $display("test complex done");
    conclude();
  end
endmodule
`default_nettype wire
